// >>> serial_port_pin_mux_tb.sv
// testbench for the serial port pin multiplexer
module serial_port_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spmux_pkg::*;
  logic clk_sys = 0, rst = 1, dm_wr = 0, pat = 0, ptd = 0, fl = 0, fla = 0;
  logic [13:0] dm_addr = '0;
  logic [15:0] dm_wdata = '0;
  logic [15:0] dm_rdata;
  logic [4:0] pins;
  spmux_port_in_t port_in;
  spmux_core_in_t core_in;
  logic tdp, l5o, l5e, fa, fb, s;
  logic rse = 0;
  logic [11:0] exp, msk;
  int errors = 0, n_tests = 0;
  // ********************************
  // clock, partner and design
  // ********************************
  always #2 clk_sys = ~clk_sys;
  spmux_peer spmux_peer_inst (.pat(pat), .pins(pins)); // clock from outside, pin mode bit 3 clear
  spmux_top spmux_top_inst (.clk_sys(clk_sys), .rst(rst), .dm_addr(dm_addr), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .receive_pin_a(pins[4]),
    .receive_pin_b(pins[3]), .receive_frame_sync_in(pins[2]),
    .transmit_frame_sync_in(pins[1]), .serial_clock_pin(pins[0]), .port_transmit_data(ptd),
    .port_receive_sync_out(ptd), .port_receive_sync_oe_n(rse), .core_flag_output(fl),
    .core_flag_out_alt(fla), .port_in(port_in), .core_in(core_in), .transmit_data_pin(tdp),
    .general_line_five_out(l5o), .general_line_five_oe_n(l5e), .receive_pin_a_free(fa),
    .receive_pin_b_free(fb));
  // masked compare, an unknown in a cared bit never matches
  task automatic check(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    n_tests++;
    if (((g ^ e) & m) !== 16'h0000)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one-cycle write strobe, taken at the next edge
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    dm_addr <= a;
    dm_wdata <= d;
    dm_wr <= 1'b1;
    @(posedge clk_sys);
    dm_wr <= 1'b0;
  endtask
  // read data is registered, so look one edge after the address
  task automatic rd(input logic [13:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    dm_addr <= a;
    @(posedge clk_sys);
    #1 check(dm_rdata, e, 16'hffff);
  endtask
  task automatic summarize();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(14'h2015, 16'h0000);
    rd(14'h3fff, 16'h0000);
    wr(14'h2015, 16'hffff);
    rd(14'h2015, 16'h01ff);
    wr(14'h3fff, 16'ha5a5);
    rd(14'h3fff, 16'ha5a5);
    wr(14'h2000, 16'hffff);
    rd(14'h2000, 16'h0000);
    // walk normal, pin select, uart and alternate settings, reserved bits left zero
    for (int c = 0; c < 6; c++)
    begin
      wr(14'h2015, 16'({c[1], c[0]}) << 4);
      wr(14'h3fff, 16'(c[2]) << 10);
      for (int p = 0; p < 2; p++)
      begin
        @(posedge clk_sys);
        pat <= p[0];
        ptd <= ~p[0];
        fl <= p[0];
        fla <= p[0];
        rse <= p[0];
        @(posedge clk_sys);
        #1 s = c[0] ? ~p[0] : p[0];
        exp = {s, p[0], ~p[0], p[0], 3'b011, ~p[0], c[0], ~c[0], ~p[0], p[0]};
        msk = 12'hfff;
        if (c[1])
        begin
          exp[10] = s;
          exp[1:0] = {p[0], 1'b0};
        end
        if (c[2])
        begin
          exp[11] = 1'b0;
          exp[9] = 1'b0;
          exp[7:4] = {s, p[0], ~p[0], p[0]};
        end
        check({port_in, core_in, tdp, fa, fb, l5o, l5e}, exp, msk);
      end
    end
    // mid-run reset: both words and the routing return to their idle state
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(14'h2015, 16'h0000);
    rd(14'h3fff, 16'h0000);
    check({13'h0000, fa, fb, tdp}, 16'h0002, 16'hffff);
    summarize();
  end
endmodule

// >>> spmux_map.svh
// constants for the serial port pin multiplexer
`ifndef SPMUX_MAP_SVH
`define SPMUX_MAP_SVH
`define SPMUX_MODE_ADDR 14'h2015
`define SPMUX_SYS_ADDR 14'h3fff
`define SPMUX_MODE_W 9
`define SPMUX_SYS_W 16
`define SPMUX_RXSEL_BIT 4
`define SPMUX_UART_BIT 5
`define SPMUX_ALT_BIT 10
`define SPMUX_MODE_RST 9'h000
`define SPMUX_SYS_RST 16'h0000
`endif

// >>> spmux_peer.sv
// partner model: external serial peripheral driving the port pins
module spmux_peer
(
  input wire logic pat,
  output logic [4:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // pin pattern
  // ********************************
  // neighbours differ, so a pin routed to a neighbour's place shows up
  assign pins = {pat, ~pat, pat, ~pat, pat};
endmodule

// >>> spmux_pkg.sv
// types for the serial port pin multiplexer
package spmux_pkg;
  // signals seen by the serial port core
  typedef struct packed {
    logic receive_data;
    logic receive_sync;
    logic transmit_sync;
    logic serial_clock;
  } spmux_port_in_t;
  // core-side special functions
  typedef struct packed {
    logic flag_input;
    logic interrupt_zero_n;
    logic interrupt_one_n;
  } spmux_core_in_t;
endpackage

// >>> spmux_top.sv
// pin multiplexer between serial port one, core flags and external pins
`include "spmux_map.svh"
module spmux_top
  import spmux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [13:0] dm_addr,
  input wire logic dm_wr,
  input wire logic [15:0] dm_wdata,
  output logic [15:0] dm_rdata,
  input wire logic receive_pin_a,
  input wire logic receive_pin_b,
  input wire logic receive_frame_sync_in,
  input wire logic transmit_frame_sync_in,
  input wire logic serial_clock_pin,
  input wire logic port_transmit_data,
  input wire logic port_receive_sync_out,
  input wire logic port_receive_sync_oe_n,
  input wire logic core_flag_output,
  input wire logic core_flag_out_alt,
  output spmux_port_in_t port_in,
  output spmux_core_in_t core_in,
  output logic transmit_data_pin,
  output logic general_line_five_out,
  output logic general_line_five_oe_n,
  output logic receive_pin_a_free,
  output logic receive_pin_b_free
);
  // ********************************
  // control registers
  // ********************************
  logic [`SPMUX_MODE_W-1:0] mode_ff, nxt_mode;
  logic [`SPMUX_SYS_W-1:0] sys_ff, nxt_sys;
  logic rxsel, uart, alt, rx_pin;

  // ********************************
  // address decode
  // ********************************
  // one decode for write, read and checks, so the paths cannot drift apart
  function automatic logic is_mode_addr(input logic [13:0] a);
    return a == `SPMUX_MODE_ADDR;
  endfunction

  // system control sits in the core's own space, not the peripheral page
  function automatic logic is_sys_addr(input logic [13:0] a);
    return a == `SPMUX_SYS_ADDR;
  endfunction

  // software owns reserved bits; system word stored as written, mode word keeps only bits 8:0
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_sys = sys_ff;
    if (dm_wr && is_mode_addr(dm_addr))
    begin
      nxt_mode = dm_wdata[`SPMUX_MODE_W-1:0];
    end
    if (dm_wr && is_sys_addr(dm_addr))
    begin
      nxt_sys = dm_wdata;
    end
  end

  // async clear: both words come up in the normal routing, pin a selected
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_ff <= `SPMUX_MODE_RST;
      sys_ff <= `SPMUX_SYS_RST;
    end
    else
    begin
      mode_ff <= nxt_mode;
      sys_ff <= nxt_sys;
    end
  end

  // read data registered; unmapped addresses read zero
  logic [15:0] rdata_ff, nxt_rdata;
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (is_mode_addr(dm_addr))
    begin
      nxt_rdata = {7'h00, mode_ff};
    end
    else if (is_sys_addr(dm_addr))
    begin
      nxt_rdata = sys_ff;
    end
  end

  // registered read costs one cycle but keeps the bus output glitch free
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign dm_rdata = rdata_ff;

  // ********************************
  // pin multiplexing
  // ********************************
  // pure muxes: no added latency on the serial data path
  // decoded control bits, straight from the two registers
  assign rxsel = mode_ff[`SPMUX_RXSEL_BIT];
  assign uart = mode_ff[`SPMUX_UART_BIT];
  assign alt = sys_ff[`SPMUX_ALT_BIT];
  assign rx_pin = rxsel ? receive_pin_b : receive_pin_a;

  // port-side and core-side inputs; alternate mode parks the port's receive data and transmit sync inputs
  always_comb
  begin
    port_in.receive_data = alt ? 1'b0 : rx_pin;
    // uart: data doubles as frame sync so start bit opens a frame
    port_in.receive_sync = uart ? rx_pin : receive_frame_sync_in;
    port_in.transmit_sync = alt ? 1'b0 : transmit_frame_sync_in;
    port_in.serial_clock = serial_clock_pin;
    core_in.flag_input = alt ? rx_pin : 1'b0;
    core_in.interrupt_zero_n = alt ? receive_frame_sync_in : 1'b1;
    core_in.interrupt_one_n = alt ? transmit_frame_sync_in : 1'b1;
  end

  // alternate mode hands the transmit pin to the core flag
  assign transmit_data_pin = alt ? core_flag_out_alt : port_transmit_data;
  // shared line five / frame sync pin driver
  assign general_line_five_out = uart ? core_flag_output : port_receive_sync_out;
  assign general_line_five_oe_n = uart ? 1'b0 : port_receive_sync_oe_n;
  // free flags follow the select bit only; the pin driver itself lives elsewhere
  assign receive_pin_a_free = rxsel;
  assign receive_pin_b_free = ~rxsel;

  // ********************************
  // checks
  // ********************************
  // checks see settled values; all are gated off while reset is high
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // register writes land at the strobe edge, seen one cycle later
  chk_mode_write: assert property (dm_wr && is_mode_addr(dm_addr) |=>
    mode_ff == $past(dm_wdata[`SPMUX_MODE_W-1:0]))
    else $error("mode control write not taken");
  chk_sys_write: assert property (dm_wr && is_sys_addr(dm_addr) |=>
    alt == $past(dm_wdata[`SPMUX_ALT_BIT]))
    else $error("alternate select not taken");

  // read path: one cycle behind the address, unmapped words read zero
  chk_rdata_mode: assert property (is_mode_addr(dm_addr) |=>
    dm_rdata == {7'h00, $past(mode_ff)})
    else $error("mode control read back wrong");
  chk_rdata_none: assert property (!is_mode_addr(dm_addr) &&
    !is_sys_addr(dm_addr) |=> dm_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // receive pin selection while the port owns the receive line
  chk_rx_select: assert property (!alt && mode_ff[`SPMUX_RXSEL_BIT] |->
    port_in.receive_data == receive_pin_b)
    else $error("receive pin b not routed");
  chk_rx_default: assert property (!alt && !mode_ff[`SPMUX_RXSEL_BIT] |->
    port_in.receive_data == receive_pin_a)
    else $error("receive pin a not routed");

  // uart emulation: data doubles as frame sync, flag owns line five
  chk_uart_tie: assert property (uart && !alt |->
    port_in.receive_sync == port_in.receive_data)
    else $error("uart receive tie broken");
  chk_uart_sync_pin: assert property (uart |->
    port_in.receive_sync == (mode_ff[`SPMUX_RXSEL_BIT] ? receive_pin_b : receive_pin_a))
    else $error("uart frame sync not from receive pin");
  chk_flag_drive: assert property (uart |-> !general_line_five_oe_n &&
    general_line_five_out == core_flag_output)
    else $error("flag not driven on line five");
  chk_line_five_port: assert property (!uart |->
    general_line_five_out == port_receive_sync_out &&
    general_line_five_oe_n == port_receive_sync_oe_n)
    else $error("line five not left to the port");

  // alternate configuration: flags and interrupts take the serial pins
  chk_alt_flags: assert property (alt |-> transmit_data_pin == core_flag_out_alt &&
    core_in.flag_input == (mode_ff[`SPMUX_RXSEL_BIT] ? receive_pin_b : receive_pin_a))
    else $error("alternate flag routing wrong");
  chk_alt_irq: assert property (alt |->
    core_in.interrupt_zero_n == receive_frame_sync_in &&
    core_in.interrupt_one_n == transmit_frame_sync_in)
    else $error("alternate interrupt routing wrong");
  chk_alt_quiet: assert property (alt |-> !port_in.receive_data &&
    !port_in.transmit_sync)
    else $error("port inputs not parked in alternate mode");

  // the serial clock is never taken away
  chk_clock_kept: assert property (port_in.serial_clock == serial_clock_pin)
    else $error("serial clock lost");

  // the pin flagged free must be the one not feeding the port
  chk_free_pin: assert property (!alt |-> receive_pin_a_free != receive_pin_b_free &&
    port_in.receive_data == (receive_pin_a_free ? receive_pin_b : receive_pin_a))
    else $error("free pin still feeds the port");

  // normal roles when neither special mode is set
  chk_normal: assert property (!uart && !alt |->
    transmit_data_pin == port_transmit_data &&
    port_in.receive_sync == receive_frame_sync_in)
    else $error("normal routing disturbed");
  chk_core_idle: assert property (!alt |-> !core_in.flag_input &&
    core_in.interrupt_zero_n && core_in.interrupt_one_n)
    else $error("core inputs not idle");

  // ********************************
  // cover points
  // ********************************
  // main scenarios worth seeing at least once
  cov_uart: cover property (uart && !alt);
  cov_uart_pin_b: cover property (uart && rxsel && !alt);
  cov_alt: cover property (alt && rxsel);
  cov_switch: cover property ($rose(uart) ##[1:40] $fell(uart));
endmodule
